// file: shared/dsgm_regs.svh
// Constants of the dual switch guard monitor.
`ifndef DSGM_REGS_SVH
`define DSGM_REGS_SVH
`define DSGM_CODE_IDLE 16'h0000
`define DSGM_CODE_NORMAL 16'h8000
`define DSGM_CODE_INIT 16'h8001
`define DSGM_CODE_CLOSED 16'h8002
`define DSGM_CODE_WAIT_ACK 16'h8402
`define DSGM_CODE_OPEN_START 16'h8802
`define DSGM_CODE_OPENED 16'h8804
`define DSGM_CODE_WAIT_B 16'h8806
`define DSGM_CODE_WAIT_A 16'h8808
`define DSGM_CODE_RST_ERR 16'hc001
`define DSGM_CODE_DISC_A 16'hc010
`define DSGM_CODE_DISC_B 16'hc020
`define DSGM_WINDOW_NS 0
`define DSGM_CLK_NS 20
`endif

// file: shared/dsgm_pkg.sv
// Types of the dual switch guard monitor.
package dsgm_pkg;
   typedef enum logic [3:0] {
      DSGM_IDLE, DSGM_INIT, DSGM_NORMAL, DSGM_CLOSED, DSGM_WAIT_ACK,
      DSGM_OPEN_START, DSGM_OPENED, DSGM_WAIT_B, DSGM_WAIT_A,
      DSGM_RST_ERR, DSGM_DISC_A, DSGM_DISC_B
   } dsgm_state_t;
endpackage : dsgm_pkg

// file: src/dsgm_sync.sv
// Two flip-flop synchroniser for one asynchronous pin.
module dsgm_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Pin and result
   input wire logic pin_i,
   output logic sync_o
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;

   always_comb begin
      nxt_meta = pin_i;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_o = sync_ff;
endmodule : dsgm_sync

// file: src/dsgm_monitor.sv
// Dual door contact guard monitor with mismatch window and acknowledge.
`include "dsgm_regs.svh"
module dsgm_monitor
   import dsgm_pkg::*;
#(
   parameter int unsigned WINDOW_CYCLES =
      (`DSGM_WINDOW_NS + `DSGM_CLK_NS - 1) / `DSGM_CLK_NS,
   parameter int unsigned CNT_W = 24
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Control
   input wire logic enable_i,
   input wire logic auto_acknowledge_i,
   input wire logic power_up_acknowledge_i,
   // Field pins
   input wire logic door_contact_a_i,
   input wire logic door_contact_b_i,
   input wire logic operator_reset_i,
   // Status
   output logic ready_o,
   output logic guard_safe_out_o,
   output logic hazard_stop_request_o,
   output logic ack_pending_o,
   output logic error_o,
   output logic [15:0] diagnostic_word_o
);
   // A window that the counter cannot reach would never expire.
   if (CNT_W < 1 || WINDOW_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_window
      $error("Mismatch window does not fit the counter width.");
   end

   logic ca;
   logic cb;
   logic rst_in;
   dsgm_state_t state_ff;
   dsgm_state_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic rst_prev_ff;
   logic nxt_rst_prev;
   logic [15:0] code_ff;
   logic [15:0] nxt_code;
   logic rst_rise;
   logic expired;

   dsgm_sync u_sync_a (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .pin_i(door_contact_a_i), .sync_o(ca));
   dsgm_sync u_sync_b (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .pin_i(door_contact_b_i), .sync_o(cb));
   dsgm_sync u_sync_r (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .pin_i(operator_reset_i), .sync_o(rst_in));

   assign rst_rise = rst_in && !rst_prev_ff;
   // A zero window expires in the first cycle of disagreement.
   assign expired = (cnt_ff >= CNT_W'(WINDOW_CYCLES));

   always_comb begin
      nxt_state = state_ff;
      nxt_rst_prev = rst_in;
      nxt_cnt = '0;
      if (!enable_i) begin
         nxt_state = DSGM_IDLE;
      end else begin
         unique case (state_ff)
            DSGM_IDLE: nxt_state = DSGM_INIT;
            DSGM_INIT: begin
               if (ca && cb) begin
                  if (power_up_acknowledge_i) begin
                     nxt_state = DSGM_NORMAL;
                  end else begin
                     nxt_state = DSGM_WAIT_ACK;
                  end
               end else if (!ca && !cb) begin
                  nxt_state = DSGM_OPENED;
               end else begin
                  nxt_state = DSGM_OPEN_START;
               end
            end
            DSGM_NORMAL: begin
               // One contact low is enough to leave normal.
               if (!ca || !cb) begin
                  nxt_state = (!ca && !cb) ? DSGM_OPENED : DSGM_OPEN_START;
               end
            end
            DSGM_OPEN_START: begin
               // Full opening needed before closing counts.
               if (!ca && !cb) begin
                  nxt_state = DSGM_OPENED;
               end
            end
            DSGM_OPENED: begin
               if (ca && cb) begin
                  nxt_state = DSGM_CLOSED;
               end else if (ca) begin
                  nxt_state = DSGM_WAIT_B;
               end else if (cb) begin
                  nxt_state = DSGM_WAIT_A;
               end
            end
            DSGM_WAIT_B, DSGM_WAIT_A: begin
               nxt_cnt = cnt_ff + CNT_W'(1);
               if (!ca && !cb) begin
                  nxt_state = DSGM_OPENED;
               end else if (ca && cb) begin
                  nxt_state = DSGM_CLOSED;
               end else if (expired) begin
                  nxt_state = (state_ff == DSGM_WAIT_B) ?
                     DSGM_DISC_A : DSGM_DISC_B;
               end else if ((state_ff == DSGM_WAIT_B) != ca) begin
                  nxt_state = DSGM_OPEN_START;
               end
            end
            DSGM_CLOSED: begin
               if (!ca || !cb) begin
                  nxt_state = DSGM_OPEN_START;
               end else if (auto_acknowledge_i) begin
                  nxt_state = DSGM_NORMAL;
               end else begin
                  nxt_state = DSGM_WAIT_ACK;
               end
            end
            DSGM_WAIT_ACK: begin
               if (!ca || !cb) begin
                  nxt_state = DSGM_OPEN_START;
               end else if (rst_rise) begin
                  nxt_state = DSGM_NORMAL;
               end else if (rst_in) begin
                  nxt_state = DSGM_RST_ERR;
               end
            end
            DSGM_RST_ERR: begin
               if (!rst_in) begin
                  nxt_state = DSGM_WAIT_ACK;
               end
            end
            DSGM_DISC_A, DSGM_DISC_B: begin
               if (!ca && !cb) begin
                  nxt_state = DSGM_OPENED;
               end
            end
            default: nxt_state = DSGM_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_ff <= DSGM_IDLE;
         cnt_ff <= '0;
         rst_prev_ff <= 1'b1;
         code_ff <= `DSGM_CODE_IDLE;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         // Starting high makes a reset held at power-up look static.
         rst_prev_ff <= nxt_rst_prev;
         code_ff <= nxt_code;
      end
   end

   // Flags are decoded from the state register, ack pending also from rst_in; the code word is
   // registered beside it so that it never glitches between states.
   always_comb begin
      ready_o = (state_ff != DSGM_IDLE);
      guard_safe_out_o = (state_ff == DSGM_NORMAL);
      hazard_stop_request_o = (state_ff == DSGM_OPEN_START) ||
         (state_ff == DSGM_OPENED) || (state_ff == DSGM_WAIT_B) ||
         (state_ff == DSGM_WAIT_A);
      ack_pending_o = (state_ff == DSGM_WAIT_ACK) && !rst_in;
      error_o = (state_ff == DSGM_RST_ERR) || (state_ff == DSGM_DISC_A) ||
         (state_ff == DSGM_DISC_B);
   end

   always_comb begin
      unique case (nxt_state)
         DSGM_IDLE: nxt_code = `DSGM_CODE_IDLE;
         DSGM_INIT: nxt_code = `DSGM_CODE_INIT;
         DSGM_NORMAL: nxt_code = `DSGM_CODE_NORMAL;
         DSGM_CLOSED: nxt_code = `DSGM_CODE_CLOSED;
         DSGM_WAIT_ACK: nxt_code = `DSGM_CODE_WAIT_ACK;
         DSGM_OPEN_START: nxt_code = `DSGM_CODE_OPEN_START;
         DSGM_OPENED: nxt_code = `DSGM_CODE_OPENED;
         DSGM_WAIT_B: nxt_code = `DSGM_CODE_WAIT_B;
         DSGM_WAIT_A: nxt_code = `DSGM_CODE_WAIT_A;
         DSGM_RST_ERR: nxt_code = `DSGM_CODE_RST_ERR;
         DSGM_DISC_A: nxt_code = `DSGM_CODE_DISC_A;
         DSGM_DISC_B: nxt_code = `DSGM_CODE_DISC_B;
         default: nxt_code = `DSGM_CODE_IDLE;
      endcase
   end

   assign diagnostic_word_o = code_ff;

   a_enable_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !enable_i |=> state_ff == DSGM_IDLE)
      else $error("Not idle after enable dropped.");
   a_disc_error: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == DSGM_WAIT_B && ca && !cb && expired && enable_i
      |=> diagnostic_word_o == `DSGM_CODE_DISC_A && error_o)
      else $error("Window expiry missed.");
   a_static_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == DSGM_WAIT_ACK && rst_in && rst_prev_ff && ca && cb &&
      enable_i |=> state_ff == DSGM_RST_ERR)
      else $error("Static reset not caught.");
   a_tied_noerr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == DSGM_OPENED && ca == cb |=> !error_o)
      else $error("Error with agreeing contacts.");
   a_rst_err_exit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == DSGM_RST_ERR && !rst_in && enable_i
      |=> state_ff == DSGM_WAIT_ACK)
      else $error("Reset error not left.");
   a_disc_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == DSGM_DISC_B && (ca || cb) && enable_i
      |=> state_ff == DSGM_DISC_B)
      else $error("Discrepancy error left early.");
   a_err_outputs: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      error_o |-> ready_o && !guard_safe_out_o && !hazard_stop_request_o
      && !ack_pending_o)
      else $error("Wrong outputs in error state.");
   a_safe_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      guard_safe_out_o && (!ca || !cb) |=> !guard_safe_out_o)
      else $error("Guard safe held after contact opened.");
   a_ack_normal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == DSGM_WAIT_ACK && rst_rise && ca && cb && enable_i
      |=> state_ff == DSGM_NORMAL && guard_safe_out_o)
      else $error("Acknowledge did not reach normal.");
   c_normal: cover property (@(posedge clk_i) state_ff == DSGM_NORMAL);
   c_disc: cover property (@(posedge clk_i) state_ff == DSGM_DISC_A);
   c_rst_err: cover property (@(posedge clk_i) state_ff == DSGM_RST_ERR);
endmodule : dsgm_monitor

// file: verif/dsgm_guard_model.sv
// Behavioural model of the two door contacts and the operator button.
module dsgm_guard_model (
   // Clock
   input wire logic clk_i,
   // Commands from the bench
   input wire logic close_a_i,
   input wire logic close_b_i,
   input wire logic press_i,
   // Field pins
   output logic door_contact_a_o,
   output logic door_contact_b_o,
   output logic operator_reset_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Contacts move just after a rising edge of the monitor clock, so they
   // are synchronous to the monitor; a separate command per contact lets
   // the bench skew them as far apart as it wants.
   initial begin
      door_contact_a_o = 1'b0;
      door_contact_b_o = 1'b0;
      operator_reset_o = 1'b0;
   end

   always @(posedge clk_i) begin
      door_contact_a_o <= close_a_i;
      door_contact_b_o <= close_b_i;
      operator_reset_o <= press_i;
   end
endmodule : dsgm_guard_model

// file: verif/test_dual_switch_guard_monitor.sv
// Directed testbench of the dual switch guard monitor.
`include "dsgm_regs.svh"
module test_dual_switch_guard_monitor;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic enable_i = 1'b0;
   logic auto_acknowledge_i = 1'b0;
   logic power_up_acknowledge_i = 1'b0;
   logic ca = 1'b0;
   logic cb = 1'b0;
   logic press = 1'b0;
   logic door_contact_a;
   logic door_contact_b;
   logic operator_reset;
   logic ready_o;
   logic guard_safe_out_o;
   logic hazard_stop_request_o;
   logic ack_pending_o;
   logic error_o;
   logic [15:0] diagnostic_word_o;
   int n_fail = 0;
   int tests_run = 0;

   always #10 clk_i = ~clk_i;

   dsgm_guard_model partner (.clk_i(clk_i), .close_a_i(ca),
      .close_b_i(cb), .press_i(press), .door_contact_a_o(door_contact_a),
      .door_contact_b_o(door_contact_b), .operator_reset_o(operator_reset));

   // A short window keeps the discrepancy runs brief.
   dsgm_monitor #(.WINDOW_CYCLES(8), .CNT_W(24)) uut (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .enable_i(enable_i),
      .auto_acknowledge_i(auto_acknowledge_i),
      .power_up_acknowledge_i(power_up_acknowledge_i),
      .door_contact_a_i(door_contact_a), .door_contact_b_i(door_contact_b),
      .operator_reset_i(operator_reset), .ready_o(ready_o),
      .guard_safe_out_o(guard_safe_out_o),
      .hazard_stop_request_o(hazard_stop_request_o),
      .ack_pending_o(ack_pending_o), .error_o(error_o),
      .diagnostic_word_o(diagnostic_word_o));

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_cyc

   // Flags are ready, guard safe, hazard stop, ack pending, error.
   task automatic check(input logic [15:0] code, input logic [4:0] fl);
      logic [4:0] got;
      got = {ready_o, guard_safe_out_o, hazard_stop_request_o,
         ack_pending_o, error_o};
      tests_run++;
      if ({diagnostic_word_o, got} !== {code, fl}) begin
         n_fail++;
         $display("mismatch at %0t: got %h %b expected %h %b", $time,
            diagnostic_word_o, got, code, fl);
      end
   endtask : check

   task automatic finish_test();
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   // The whole sequence needs about 150 cycles; allow about twenty times that.
   initial begin
      repeat (3000) @(posedge clk_i);
      n_fail++;
      finish_test();
   end

   initial begin
      wait_cyc(12);
      sys_rst_i = 1'b0;
      check(`DSGM_CODE_IDLE, 5'h00);
      enable_i = 1'b1;
      wait_cyc(1);
      check(`DSGM_CODE_INIT, 5'h10);
      wait_cyc(6);
      check(`DSGM_CODE_OPENED, 5'h14);
      ca = 1'b1;
      wait_cyc(6);
      check(`DSGM_CODE_WAIT_B, 5'h14);
      cb = 1'b1;
      wait_cyc(6);
      check(`DSGM_CODE_WAIT_ACK, 5'h12);
      press = 1'b1;
      wait_cyc(6);
      check(`DSGM_CODE_NORMAL, 5'h18);
      press = 1'b0;
      ca = 1'b0;
      wait_cyc(6);
      check(`DSGM_CODE_OPEN_START, 5'h14);
      cb = 1'b0;
      wait_cyc(6);
      check(`DSGM_CODE_OPENED, 5'h14);
      cb = 1'b1;
      wait_cyc(20);
      check(`DSGM_CODE_DISC_B, 5'h11);
      ca = 1'b1;
      wait_cyc(6);
      check(`DSGM_CODE_DISC_B, 5'h11);
      ca = 1'b0;
      cb = 1'b0;
      wait_cyc(6);
      check(`DSGM_CODE_OPENED, 5'h14);
      ca = 1'b1;
      wait_cyc(20);
      check(`DSGM_CODE_DISC_A, 5'h11);
      ca = 1'b0;
      press = 1'b1;
      wait_cyc(6);
      ca = 1'b1;
      cb = 1'b1;
      wait_cyc(12);
      check(`DSGM_CODE_RST_ERR, 5'h11);
      press = 1'b0;
      wait_cyc(6);
      check(`DSGM_CODE_WAIT_ACK, 5'h12);
      press = 1'b1;
      wait_cyc(6);
      check(`DSGM_CODE_NORMAL, 5'h18);
      press = 1'b0;
      ca = 1'b0;
      cb = 1'b0;
      wait_cyc(6);
      auto_acknowledge_i = 1'b1;
      ca = 1'b1;
      cb = 1'b1;
      wait_cyc(8);
      check(`DSGM_CODE_NORMAL, 5'h18);
      enable_i = 1'b0;
      wait_cyc(1);
      check(`DSGM_CODE_IDLE, 5'h00);
      auto_acknowledge_i = 1'b0;
      power_up_acknowledge_i = 1'b1;
      enable_i = 1'b1;
      wait_cyc(6);
      check(`DSGM_CODE_NORMAL, 5'h18);
      finish_test();
   end
endmodule : test_dual_switch_guard_monitor
